// ===== core/fmt_consts.svh
`ifndef FMT_CONSTS_SVH
`define FMT_CONSTS_SVH

// ==========================================================
// Link address and transfer start points
`define FMT_I2C_ADDR 7'h64
`define FMT_WR_FIRST_REG 4'h2
`define FMT_RD_FIRST_REG 4'ha

// ==========================================================
// Register offsets
`define FMT_REG_DEVICE_IDENTITY 4'h0
`define FMT_REG_SILICON_REVISION 4'h1
`define FMT_REG_AUDIO_DEMOD_CONFIG 4'h2
`define FMT_REG_TUNING_SETUP 4'h3
`define FMT_REG_SYSTEM_SETUP 4'h4
`define FMT_REG_SEEK_SETUP_A 4'h5
`define FMT_REG_POWER_SETUP 4'h6
`define FMT_REG_PAD_SETUP 4'h7
`define FMT_REG_SPARE_WORD_08 4'h8
`define FMT_REG_SEEK_SETUP_B 4'h9
`define FMT_REG_TUNE_STATE_AND_CHANNEL 4'ha
`define FMT_REG_SIGNAL_STRENGTH 4'hb

// ==========================================================
// Host-writable bits per register, then the revision read mask
`define FMT_MASK_AUDIO 16'hf3ff
`define FMT_MASK_TUNING 16'hbfff
`define FMT_MASK_SYSTEM 16'h2000
`define FMT_MASK_SEEK_A 16'he0ff
`define FMT_MASK_POWER 16'hcf0f
`define FMT_MASK_SEEK_B 16'hffff
`define FMT_MASK_NONE 16'h0000
`define FMT_MASK_REVISION 16'hfc00

// ==========================================================
// Reset values
`define FMT_RST_ZERO 16'h0000
`define FMT_RST_PAD 16'h7000
`define FMT_RST_SEEK_B 16'h4010

// ==========================================================
// Field positions
`define FMT_SMUTE_OFF_BIT 15
`define FMT_HARD_MUTE_BIT 14
`define FMT_MONO_BIT 13
`define FMT_DEEMPH_BIT 12
`define FMT_BLEND_MSB 9
`define FMT_BLEND_LSB 8
`define FMT_SPEED_MSB 7
`define FMT_SPEED_LSB 6
`define FMT_DEPTH_MSB 5
`define FMT_DEPTH_LSB 4
`define FMT_LEVEL_MSB 3
`define FMT_LEVEL_LSB 0
`define FMT_TUNE_BIT 15
`define FMT_BAND_MSB 13
`define FMT_BAND_LSB 12
`define FMT_STEP_MSB 11
`define FMT_STEP_LSB 10
`define FMT_CHAN_MSB 9
`define FMT_CHAN_LSB 0

// ==========================================================
// Audio figures
`define FMT_DEEMPH_US_SLOW 7'd75
`define FMT_DEEMPH_US_FAST 7'd50
`define FMT_DEPTH_MAX_DB 5'd16
`define FMT_LEVEL_FULL 4'hf
`define FMT_BLEND_SPAN_DB 6'd18
`define FMT_BLEND_LOW_0 6'd31
`define FMT_BLEND_LOW_1 6'd37
`define FMT_BLEND_LOW_2 6'd19
`define FMT_BLEND_LOW_3 6'd25

`endif

// ===== core/fmt_pkg.sv
package fmt_pkg;

  // ==========================================================
  // Link byte engine states
  typedef enum logic [6:0] {
    FMT_IDLE     = 7'b0000001,
    FMT_ADDR     = 7'b0000010,
    FMT_ADDR_ACK = 7'b0000100,
    FMT_WR       = 7'b0001000,
    FMT_WR_ACK   = 7'b0010000,
    FMT_RD       = 7'b0100000,
    FMT_RD_ACK   = 7'b1000000
  } fmt_link_state_t;

endpackage : fmt_pkg

// ===== core/fmt_sync2.sv
`timescale 1ns/100ps

module fmt_sync2 #(
  parameter int W = 1
) (
  // ==========================================================
  // Destination clock
  input wire logic clk_i,
  // Asynchronous level
  input wire logic [W-1:0] d_i,
  // Synchronised level
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    meta_q <= d_i;
    q_o <= meta_q;
  end

endmodule : fmt_sync2

// ===== core/fmt_tuner_regs.sv
// Summary of operation
// - Offset 0 reads part number in 15:12 and maker code in 11:0.
// - Offset 1 reads revision in 15:10, low bits read zero.
// - Audio bit 15: 0 enables soft-mute, 1 disables it.
// - Audio bit 14: 0 keeps output muted, 1 releases the mute.
// - Audio bit 13: 0 automatic stereo detection, 1 forces mono.
// - Audio bit 12 picks de-emphasis of 75 us or 50 us.
// - Audio bits 9:8 pick the stereo blend signal window.
// - Audio bits 7:6 pick soft-mute speed, fastest to slowest.
// - Audio bits 5:4 pick soft-mute depth, 16 dB down to 10 dB.
// - Audio bits 3:0 set volume; zero mutes, fifteen is full scale.
// - Tuning bit 15 set by host starts tuning; stays set until the host writes 0.
// - Tuning bits 13:12 choose the band.
// - Tuning bits 11:10 choose the channel step.
// - Reserved bits are read-only; host writes leave them unchanged.
// - Reset loads 7000h pad word, 4010h seek word, zero elsewhere.
// - Device answers link address 1100100b; last address bit is read.
// - Writes start at register 2, high byte first, wrapping around.
// - Reads start at register 10, high byte first; host NACKs last.
// - A STOP on the link clears the internal byte pointer.
`timescale 1ns/100ps

`include "fmt_consts.svh"

module fmt_tuner_regs
  import fmt_pkg::*;
#(
  parameter logic [3:0] PART_NUMBER = 4'h3,      // Arbitrary value
  parameter logic [11:0] MAKER_CODE = 12'h5a1,   // Arbitrary value
  parameter logic [5:0] REVISION = 6'h05         // Arbitrary value
) (
  // ==========================================================
  // System clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Two-wire link
  input wire logic scl_clk_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Tuner status
  input wire logic tune_done_i,
  input wire logic seek_fail_i,
  input wire logic stereo_i,
  input wire logic [9:0] read_chan_i,
  input wire logic [7:0] signal_strength_i,
  // Audio control
  output logic soft_mute_off_o,
  output logic hard_mute_release_o,
  output logic force_single_channel_o,
  output logic [6:0] deemphasis_us_o,
  output logic [5:0] blend_low_dbuv_o,
  output logic [5:0] blend_high_dbuv_o,
  output logic [1:0] soft_mute_speed_o,
  output logic [4:0] soft_mute_depth_db_o,
  output logic output_muted_o,
  output logic [4:0] output_atten_db_o,
  // Tuning control
  output logic tune_start_o,
  output logic [1:0] band_choice_o,
  output logic [1:0] channel_step_o,
  output logic [9:0] channel_number_o,
  // Other configuration words
  output logic [15:0] system_setup_o,
  output logic [15:0] seek_setup_a_o,
  output logic [15:0] power_setup_o,
  output logic [15:0] seek_setup_b_o
);

  // ==========================================================
  // Register helpers
  function automatic logic [15:0] reset_word(input logic [3:0] idx);
    logic [15:0] w;
    w = `FMT_RST_ZERO;
    if (idx == `FMT_REG_PAD_SETUP) begin
      w = `FMT_RST_PAD;
    end
    if (idx == `FMT_REG_SEEK_SETUP_B) begin
      w = `FMT_RST_SEEK_B;
    end
    return w;
  endfunction : reset_word

  function automatic logic [15:0] write_mask(input logic [3:0] idx);
    logic [15:0] m;
    m = `FMT_MASK_NONE;
    unique case (idx)
      `FMT_REG_AUDIO_DEMOD_CONFIG: m = `FMT_MASK_AUDIO;
      `FMT_REG_TUNING_SETUP: m = `FMT_MASK_TUNING;
      `FMT_REG_SYSTEM_SETUP: m = `FMT_MASK_SYSTEM;
      `FMT_REG_SEEK_SETUP_A: m = `FMT_MASK_SEEK_A;
      `FMT_REG_POWER_SETUP: m = `FMT_MASK_POWER;
      `FMT_REG_SEEK_SETUP_B: m = `FMT_MASK_SEEK_B;
      default: m = `FMT_MASK_NONE;
    endcase
    return m;
  endfunction : write_mask

  // ==========================================================
  // Start and stop detection
  // These two toggles run on the data line's own edges; the link is
  // idle while reset is held, so async clear to zero is safe.
  logic start_tgl_q;
  logic stop_tgl_q;

  always_ff @(negedge sda_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      start_tgl_q <= 1'b0;
    end else if (scl_clk_i) begin
      start_tgl_q <= ~start_tgl_q;
    end
  end

  always_ff @(posedge sda_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stop_tgl_q <= 1'b0;
    end else if (scl_clk_i) begin
      stop_tgl_q <= ~stop_tgl_q;
    end
  end

  // ==========================================================
  // Link byte engine
  fmt_link_state_t state_q, state_d;
  logic start_seen_q;
  logic stop_seen_q;
  logic [7:0] shift_q;
  logic [2:0] bit_q;
  logic [4:0] ptr_q;
  logic rw_q;
  logic [7:0] hi_q;
  logic wr_tgl_q;
  logic sack_q;
  logic [15:0] stat_a_q;
  logic [15:0] stat_b_q;
  logic [15:0] regs_q [16];

  // The toggles settle a full setup time before the next clock rise,
  // so the link clock may sample them directly.
  wire start_ev = start_tgl_q != start_seen_q;
  wire stop_ev = stop_tgl_q != stop_seen_q;
  wire [7:0] byte_in = {shift_q[6:0], sda_i};
  wire last_bit = bit_q == 3'h7;
  wire addr_hit = byte_in[7:1] == `FMT_I2C_ADDR;
  wire in_byte = (state_q == FMT_WR) || (state_q == FMT_RD);
  wire [3:0] wr_idx = `FMT_WR_FIRST_REG + ptr_q[4:1];
  wire [3:0] rd_idx = `FMT_RD_FIRST_REG + ptr_q[4:1];
  wire commit = (state_q == FMT_WR) && last_bit && ptr_q[0];
  wire [15:0] wr_mask = write_mask(wr_idx);
  wire [15:0] ident_word = {PART_NUMBER, MAKER_CODE};
  wire [15:0] rev_word = {REVISION, 10'h000} & `FMT_MASK_REVISION;

  wire [15:0] rd_word =
    (rd_idx == `FMT_REG_DEVICE_IDENTITY) ? ident_word :
    (rd_idx == `FMT_REG_SILICON_REVISION) ? rev_word :
    (rd_idx == `FMT_REG_TUNE_STATE_AND_CHANNEL) ? stat_a_q :
    (rd_idx == `FMT_REG_SIGNAL_STRENGTH) ? stat_b_q :
    regs_q[rd_idx];
  wire [7:0] rd_byte = ptr_q[0] ? rd_word[7:0] : rd_word[15:8];
  wire rd_bit = rd_byte[~bit_q];

  wire [2:0] bit_d = start_ev ? 3'h1 :
                     ((state_q == FMT_ADDR) || in_byte) ? bit_q + 3'h1 :
                     3'h0;
  wire [4:0] ptr_d = (start_ev || stop_ev) ? 5'h00 :
                     (in_byte && last_bit) ? ptr_q + 5'h01 :
                     ptr_q;
  wire rw_d = ((state_q == FMT_ADDR) && last_bit) ? sda_i : rw_q;
  wire [7:0] hi_d = ((state_q == FMT_WR) && last_bit && !ptr_q[0]) ?
                    byte_in : hi_q;

  always_comb begin
    state_d = state_q;
    if (start_ev) begin
      state_d = FMT_ADDR;
    end else if (stop_ev) begin
      state_d = FMT_IDLE;
    end else begin
      unique case (state_q)
        FMT_IDLE: state_d = FMT_IDLE;
        FMT_ADDR: begin
          if (last_bit) begin
            state_d = addr_hit ? FMT_ADDR_ACK : FMT_IDLE;
          end
        end
        FMT_ADDR_ACK: state_d = rw_q ? FMT_RD : FMT_WR;
        FMT_WR: state_d = last_bit ? FMT_WR_ACK : FMT_WR;
        FMT_WR_ACK: state_d = FMT_WR;
        FMT_RD: state_d = last_bit ? FMT_RD_ACK : FMT_RD;
        // A missing acknowledge ends the read burst
        FMT_RD_ACK: state_d = sda_i ? FMT_IDLE : FMT_RD;
        default: state_d = FMT_IDLE;
      endcase
    end
  end

  always_ff @(posedge scl_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= FMT_IDLE;
      start_seen_q <= 1'b0;
      stop_seen_q <= 1'b0;
      shift_q <= 8'h00;
      bit_q <= 3'h0;
      ptr_q <= 5'h00;
      rw_q <= 1'b0;
      hi_q <= 8'h00;
    end else begin
      state_q <= state_d;
      start_seen_q <= start_tgl_q;
      stop_seen_q <= stop_tgl_q;
      shift_q <= byte_in;
      bit_q <= bit_d;
      ptr_q <= ptr_d;
      rw_q <= rw_d;
      hi_q <= hi_d;
    end
  end

  // ==========================================================
  // Register array, written in the link domain
  always_ff @(posedge scl_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < 16; i++) begin
        regs_q[i] <= reset_word(4'(i));
      end
      wr_tgl_q <= 1'b0;
    end else if (commit) begin
      // Identity and status words have an empty mask: acked, unchanged
      regs_q[wr_idx] <= (regs_q[wr_idx] & ~wr_mask) |
                        ({hi_q, byte_in} & wr_mask);
      wr_tgl_q <= ~wr_tgl_q;
    end
  end

  // ==========================================================
  // Data line drive, changed on the falling clock edge
  always_ff @(negedge scl_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sda_oe_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      unique case (state_q)
        FMT_ADDR_ACK, FMT_WR_ACK: sda_oe_o <= 1'b1;
        FMT_RD: sda_oe_o <= ~rd_bit;
        default: sda_oe_o <= 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Status snapshot handshake into the link domain
  logic sreq_q;
  logic sreq_s;
  logic sack_s;
  logic [15:0] snap_a_q;
  logic [15:0] snap_b_q;

  fmt_sync2 #(.W(1)) u_sync_sreq (
    .clk_i(scl_clk_i),
    .d_i(sreq_q),
    .q_o(sreq_s)
  );

  fmt_sync2 #(.W(1)) u_sync_sack (
    .clk_i(clk_i),
    .d_i(sack_q),
    .q_o(sack_s)
  );

  // Snapshots held stable until the link side acknowledges the copy
  always_ff @(posedge scl_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sack_q <= 1'b0;
      stat_a_q <= `FMT_RST_ZERO;
      stat_b_q <= `FMT_RST_ZERO;
    end else if (sreq_s != sack_q) begin
      sack_q <= ~sack_q;
      stat_a_q <= snap_a_q;
      stat_b_q <= snap_b_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sreq_q <= 1'b0;
      snap_a_q <= `FMT_RST_ZERO;
      snap_b_q <= `FMT_RST_ZERO;
    end else if (sack_s == sreq_q) begin
      sreq_q <= ~sreq_q;
      snap_a_q <= {1'b0, tune_done_i, seek_fail_i, 2'b00, stereo_i,
                   read_chan_i};
      snap_b_q <= {8'h00, signal_strength_i};
    end
  end

  // ==========================================================
  // Configuration transfer into the system domain
  // Words stay stable for at least sixteen link clocks after a commit,
  // far longer than the three system clocks the toggle needs.
  logic wr_s;
  logic wr_seen_q;

  fmt_sync2 #(.W(1)) u_sync_wr (
    .clk_i(clk_i),
    .d_i(wr_tgl_q),
    .q_o(wr_s)
  );

  wire load_cfg = !rst_b_i || (wr_s != wr_seen_q);
  wire [15:0] aud_w = rst_b_i ? regs_q[`FMT_REG_AUDIO_DEMOD_CONFIG] :
                      `FMT_RST_ZERO;
  wire [15:0] tun_w = rst_b_i ? regs_q[`FMT_REG_TUNING_SETUP] :
                      `FMT_RST_ZERO;
  wire [15:0] sys_w = rst_b_i ? regs_q[`FMT_REG_SYSTEM_SETUP] :
                      `FMT_RST_ZERO;
  wire [15:0] ska_w = rst_b_i ? regs_q[`FMT_REG_SEEK_SETUP_A] :
                      `FMT_RST_ZERO;
  wire [15:0] pwr_w = rst_b_i ? regs_q[`FMT_REG_POWER_SETUP] :
                      `FMT_RST_ZERO;
  wire [15:0] skb_w = rst_b_i ? regs_q[`FMT_REG_SEEK_SETUP_B] :
                      `FMT_RST_SEEK_B;

  wire [1:0] blend_code = aud_w[`FMT_BLEND_MSB:`FMT_BLEND_LSB];
  wire [5:0] blend_low = (blend_code == 2'h0) ? `FMT_BLEND_LOW_0 :
                         (blend_code == 2'h1) ? `FMT_BLEND_LOW_1 :
                         (blend_code == 2'h2) ? `FMT_BLEND_LOW_2 :
                         `FMT_BLEND_LOW_3;
  wire [1:0] depth_code = aud_w[`FMT_DEPTH_MSB:`FMT_DEPTH_LSB];
  wire [4:0] depth_db = `FMT_DEPTH_MAX_DB - {2'b00, depth_code, 1'b0};
  wire [3:0] level = aud_w[`FMT_LEVEL_MSB:`FMT_LEVEL_LSB];
  wire [3:0] level_gap = `FMT_LEVEL_FULL - level;
  wire [4:0] atten_db = {level_gap, 1'b0};

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wr_seen_q <= 1'b0;
    end else begin
      wr_seen_q <= wr_s;
    end
  end

  always_ff @(posedge clk_i) begin
    if (load_cfg) begin
      soft_mute_off_o <= aud_w[`FMT_SMUTE_OFF_BIT];
      hard_mute_release_o <= aud_w[`FMT_HARD_MUTE_BIT];
      force_single_channel_o <= aud_w[`FMT_MONO_BIT];
      deemphasis_us_o <= aud_w[`FMT_DEEMPH_BIT] ?
                         `FMT_DEEMPH_US_FAST : `FMT_DEEMPH_US_SLOW;
      blend_low_dbuv_o <= blend_low;
      blend_high_dbuv_o <= blend_low + `FMT_BLEND_SPAN_DB;
      soft_mute_speed_o <= aud_w[`FMT_SPEED_MSB:`FMT_SPEED_LSB];
      soft_mute_depth_db_o <= depth_db;
      output_muted_o <= level == 4'h0;
      output_atten_db_o <= atten_db;
    end
  end

  always_ff @(posedge clk_i) begin
    if (load_cfg) begin
      tune_start_o <= tun_w[`FMT_TUNE_BIT];
      band_choice_o <= tun_w[`FMT_BAND_MSB:`FMT_BAND_LSB];
      channel_step_o <= tun_w[`FMT_STEP_MSB:`FMT_STEP_LSB];
      channel_number_o <= tun_w[`FMT_CHAN_MSB:`FMT_CHAN_LSB];
      system_setup_o <= sys_w;
      seek_setup_a_o <= ska_w;
      power_setup_o <= pwr_w;
      seek_setup_b_o <= skb_w;
    end
  end

endmodule : fmt_tuner_regs

// ===== tb/fmt_tuner_regs_chk.sv
`timescale 1ns/100ps

module fmt_tuner_regs_chk (
  // ==========
  // Clock, reset and link
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic scl_clk_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  // Decoded controls
  input wire logic [6:0] deemphasis_us_o,
  input wire logic [5:0] blend_low_dbuv_o,
  input wire logic [5:0] blend_high_dbuv_o,
  input wire logic [4:0] soft_mute_depth_db_o,
  input wire logic output_muted_o,
  input wire logic [4:0] output_atten_db_o,
  input wire logic tune_start_o,
  // Raw words
  input wire logic [15:0] system_setup_o,
  input wire logic [15:0] seek_setup_a_o,
  input wire logic [15:0] power_setup_o,
  input wire logic [15:0] seek_setup_b_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // ==========
  // Six idle samples outlast the crossing latency of a commit
  sequence link_idle;
    scl_clk_i [*6];
  endsequence
  sequence held_reset;
    !rst_b_i ##1 !rst_b_i;
  endsequence

  a_reset_words_load: assert property (disable iff (1'b0)
    held_reset |-> seek_setup_b_o == 16'h4010 && power_setup_o == 16'h0
      && output_muted_o && !tune_start_o && !sda_oe_o)
    else $error("reset decode wrong");
  a_mute_atten_tie: assert property (
    output_muted_o == (output_atten_db_o == 5'd30))
    else $error("mute flag and attenuation disagree");
  a_atten_even_steps: assert property (
    !output_atten_db_o[0] && output_atten_db_o <= 5'd30)
    else $error("attenuation off the 2 dB grid");
  a_deemph_pair: assert property (
    deemphasis_us_o inside {7'd75, 7'd50})
    else $error("de-emphasis value illegal");
  a_blend_window: assert property (
    blend_high_dbuv_o == blend_low_dbuv_o + 6'd18
      && blend_low_dbuv_o inside {6'd31, 6'd37, 6'd19, 6'd25})
    else $error("blend window illegal");
  a_depth_values: assert property (
    soft_mute_depth_db_o inside {5'd16, 5'd14, 5'd12, 5'd10})
    else $error("soft-mute depth illegal");
  a_reserved_zero: assert property (
    (system_setup_o & 16'hdfff) == 16'h0 && seek_setup_a_o[12:8] == 5'h0
      && power_setup_o[13:12] == 2'h0 && power_setup_o[7:4] == 4'h0)
    else $error("reserved bit set");
  a_drive_low_only: assert property (
    sda_oe_o |-> !sda_o)
    else $error("data line driven high");
  a_idle_released: assert property (
    link_idle |-> !sda_oe_o)
    else $error("data line held while link idle");
  a_words_hold_idle: assert property (
    link_idle |=> $stable({system_setup_o, seek_setup_a_o, power_setup_o,
      seek_setup_b_o, output_atten_db_o, tune_start_o}))
    else $error("configuration changed without link traffic");
endmodule : fmt_tuner_regs_chk

bind fmt_tuner_regs fmt_tuner_regs_chk u_chk (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .scl_clk_i(scl_clk_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .deemphasis_us_o(deemphasis_us_o),
  .blend_low_dbuv_o(blend_low_dbuv_o), .blend_high_dbuv_o(blend_high_dbuv_o),
  .soft_mute_depth_db_o(soft_mute_depth_db_o),
  .output_muted_o(output_muted_o), .output_atten_db_o(output_atten_db_o),
  .tune_start_o(tune_start_o), .system_setup_o(system_setup_o),
  .seek_setup_a_o(seek_setup_a_o), .power_setup_o(power_setup_o),
  .seek_setup_b_o(seek_setup_b_o)
);

// ===== tb/fmt_host_model.sv
`timescale 1ns/100ps

module fmt_host_model (
  // ==========
  // Link lines
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  // Clock stands high between frames; released data floats to pull-up
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic bit_io(input logic b, output logic r);
    scl_o = 1'b0;
    #7 sda_o = b;
    #8 scl_o = 1'b1;
    #7 r = sda_i;
    #8;
  endtask : bit_io

  task automatic byte_io(input logic [7:0] d, input logic ab,
                         output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ab, a);
  endtask : byte_io

  task automatic start_f();
    #22 sda_o = 1'b0;
    #15;
  endtask : start_f

  task automatic stop_f();
    scl_o = 1'b0;
    #7 sda_o = 1'b0;
    #8 scl_o = 1'b1;
    #15 sda_o = 1'b1;
    #15;
  endtask : stop_f

  // 18 clocks per word keeps above the 16-clock rewrite spacing
  task automatic wr_frame(input logic [6:0] a, input logic [15:0] w[$],
                          output logic ok);
    logic [7:0] q;
    logic k;
    start_f();
    byte_io({a, 1'b0}, 1'b1, q, k);
    ok = !k;
    foreach (w[i]) begin
      byte_io(w[i][15:8], 1'b1, q, k);
      byte_io(w[i][7:0], 1'b1, q, k);
    end
    stop_f();
  endtask : wr_frame

  task automatic rd_frame(input int n, output logic [15:0] r[$],
                          output logic ok);
    logic [7:0] hi;
    logic [7:0] lo;
    logic k;
    r = {};
    start_f();
    byte_io({7'h64, 1'b1}, 1'b1, hi, k);
    ok = !k;
    for (int i = 0; i < n; i++) begin
      byte_io(8'hff, 1'b0, hi, k);
      byte_io(8'hff, i == n - 1, lo, k);
      r.push_back({hi, lo});
    end
    stop_f();
  endtask : rd_frame
endmodule : fmt_host_model

// ===== tb/tb.sv
`timescale 1ns/100ps

`define CHK(n, e, s) begin \
  comparisons++; \
  if ((s) !== (e)) begin \
    fail_count++; \
    $display("mismatch %s exp %0h got %0h", n, e, s); \
  end \
end

module tb;
  // Arbitrary identity values
  localparam logic [3:0] PN = 4'h6;
  localparam logic [11:0] MC = 12'h3b2;
  localparam logic [5:0] REV = 6'h11;
  localparam logic [15:0] MSK [16] = '{16'h0, 16'h0, 16'hf3ff, 16'hbfff,
    16'h2000, 16'he0ff, 16'hcf0f, 16'h0, 16'h0, 16'hffff, 16'h0, 16'h0,
    16'h0, 16'h0, 16'h0, 16'h0};
  int fail_count = 0;
  int comparisons = 0;
  logic [15:0] img [16];
  logic [15:0] w[$];
  logic ok;
  logic clk_i = 1'b0;
  // No initial value: the link flops need a real falling edge at time 0
  logic rst_b_i;
  logic scl_clk_i, sda_h, sda_o, sda_oe_o;
  logic tune_done_i = 1'b0, seek_fail_i = 1'b0, stereo_i = 1'b0;
  logic [9:0] read_chan_i = 10'h000;
  logic [7:0] signal_strength_i = 8'h00;
  logic soft_mute_off_o, hard_mute_release_o, force_single_channel_o;
  logic output_muted_o, tune_start_o;
  logic [6:0] deemphasis_us_o;
  logic [5:0] blend_low_dbuv_o, blend_high_dbuv_o;
  logic [4:0] soft_mute_depth_db_o, output_atten_db_o;
  logic [1:0] soft_mute_speed_o, band_choice_o, channel_step_o;
  logic [9:0] channel_number_o;
  logic [15:0] system_setup_o, seek_setup_a_o, power_setup_o, seek_setup_b_o;
  wire sda_w = sda_h & !(sda_oe_o & !sda_o);

  always #25 clk_i = ~clk_i;

  fmt_host_model h (.scl_o(scl_clk_i), .sda_o(sda_h), .sda_i(sda_w));

  fmt_tuner_regs #(.PART_NUMBER(PN), .MAKER_CODE(MC), .REVISION(REV)) dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .scl_clk_i(scl_clk_i), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .tune_done_i(tune_done_i),
    .seek_fail_i(seek_fail_i), .stereo_i(stereo_i),
    .read_chan_i(read_chan_i), .signal_strength_i(signal_strength_i),
    .soft_mute_off_o(soft_mute_off_o),
    .hard_mute_release_o(hard_mute_release_o),
    .force_single_channel_o(force_single_channel_o),
    .deemphasis_us_o(deemphasis_us_o), .blend_low_dbuv_o(blend_low_dbuv_o),
    .blend_high_dbuv_o(blend_high_dbuv_o),
    .soft_mute_speed_o(soft_mute_speed_o),
    .soft_mute_depth_db_o(soft_mute_depth_db_o),
    .output_muted_o(output_muted_o), .output_atten_db_o(output_atten_db_o),
    .tune_start_o(tune_start_o), .band_choice_o(band_choice_o),
    .channel_step_o(channel_step_o), .channel_number_o(channel_number_o),
    .system_setup_o(system_setup_o), .seek_setup_a_o(seek_setup_a_o),
    .power_setup_o(power_setup_o), .seek_setup_b_o(seek_setup_b_o));

  function automatic logic [5:0] blend_lo(input logic [1:0] c);
    return c[1] ? (c[0] ? 6'd25 : 6'd19) : (c[0] ? 6'd37 : 6'd31);
  endfunction : blend_lo

  task automatic init_img();
    foreach (img[i]) img[i] = 16'h0000;
    img[0] = {PN, MC};
    img[1] = {REV, 10'h000};
    img[7] = 16'h7000;
    img[9] = 16'h4010;
  endtask : init_img

  task automatic put(input logic [15:0] q[$]);
    int j;
    h.wr_frame(7'h64, q, ok);
    `CHK("ack", 1'b1, ok)
    foreach (q[i]) begin
      j = (i + 2) % 16;
      img[j] = (img[j] & ~MSK[j]) | (q[i] & MSK[j]);
    end
    repeat (10) @(posedge clk_i);
  endtask : put

  task automatic audit();
    logic [15:0] a;
    logic [15:0] t;
    a = img[2];
    t = img[3];
    `CHK("smute", a[15], soft_mute_off_o)
    `CHK("mute", a[14], hard_mute_release_o)
    `CHK("mono", a[13], force_single_channel_o)
    `CHK("deemph", a[12] ? 7'd50 : 7'd75, deemphasis_us_o)
    `CHK("blend", blend_lo(a[9:8]), blend_low_dbuv_o)
    `CHK("blendh", blend_lo(a[9:8]) + 6'd18, blend_high_dbuv_o)
    `CHK("speed", a[7:6], soft_mute_speed_o)
    `CHK("depth", 5'd16 - {a[5:4], 1'b0}, soft_mute_depth_db_o)
    `CHK("vmute", a[3:0] == 4'h0, output_muted_o)
    `CHK("atten", 5'd30 - {a[3:0], 1'b0}, output_atten_db_o)
    `CHK("tune", t[15], tune_start_o)
    `CHK("band", t[13:12], band_choice_o)
    `CHK("step", t[11:10], channel_step_o)
    `CHK("chan", t[9:0], channel_number_o)
    `CHK("sys", img[4], system_setup_o)
    `CHK("seeka", img[5], seek_setup_a_o)
    `CHK("pwr", img[6], power_setup_o)
    `CHK("seekb", img[9], seek_setup_b_o)
  endtask : audit

  task automatic check();
    logic [15:0] r[$];
    h.rd_frame(16, r, ok);
    `CHK("rack", 1'b1, ok)
    img[10] = {1'b0, tune_done_i, seek_fail_i, 2'b00, stereo_i, read_chan_i};
    img[11] = {8'h00, signal_strength_i};
    foreach (r[i]) begin
      `CHK("word", img[(i + 10) % 16], r[i])
    end
  endtask : check

  task automatic close_out();
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  initial begin
    #1000000;
    fail_count++;
    close_out();
  end

  initial begin
    rst_b_i <= 1'b0;
    void'($urandom(99062));
    init_img();
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    {tune_done_i, seek_fail_i, stereo_i} <= 3'($urandom);
    read_chan_i <= 10'($urandom);
    signal_strength_i <= 8'($urandom);
    repeat (4) @(posedge clk_i);
    audit();
    check();
    // ==========
    // Every code of each field but the random channel number, reserved bits set on purpose
    for (int k = 0; k < 16; k++) begin
      w = {{k[3:0], 2'b11, k[1:0], k[1:0], ~k[1:0], k[3:0]},
           {k[0], 1'b1, k[2:1], k[3:2], 10'($urandom)}};
      put(w);
      audit();
    end
    h.wr_frame(7'h65, '{16'hffff}, ok);
    `CHK("foreign", 1'b0, ok)
    repeat (10) @(posedge clk_i);
    audit();
    // ==========
    // Burst wraps through identity words back to the first register
    w = {};
    repeat (17) w.push_back(16'($urandom));
    put(w);
    audit();
    check();
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    init_img();
    repeat (3) @(posedge clk_i);
    audit();
    check();
    close_out();
  end
endmodule : tb
